// *** include/cfp_params.svh ***
// Constants for the configuration fuse and protection block.
// Assumes inclusion by the package and by each design file.
`ifndef CFP_PARAMS_SVH
`define CFP_PARAMS_SVH
`define CFP_ADDR_W        22
`define CFP_OFS_DBG       22'h300006
`define CFP_OFS_CP        22'h300008
`define CFP_OFS_CPH       22'h300009
`define CFP_OFS_WP        22'h30000A
`define CFP_OFS_WPH       22'h30000B
`define CFP_OFS_TR        22'h30000C
`define CFP_OFS_TRH       22'h30000D
`define CFP_OFS_ID1       22'h3FFFFE
`define CFP_OFS_ID2       22'h3FFFFF
`define CFP_MASK_DBG      8'h85
`define CFP_MASK_BLK      8'h0F
`define CFP_MASK_CPH      8'hC0
`define CFP_MASK_WPH      8'hE0
`define CFP_MASK_TRH      8'h40
`define CFP_BIT_DEBUG     7
`define CFP_BIT_LVP       2
`define CFP_BIT_STACK     0
`define CFP_BIT_EE        7
`define CFP_BIT_BOOT      6
`define CFP_BIT_CFGWP     5
`define CFP_BOOT_END      22'h0001FF
`define CFP_BLK_SHIFT     13
`define CFP_BLK_TOP       22'h007FFF
`define CFP_CFG_LO        22'h300000
`define CFP_CFG_HI        22'h3000FF
`define CFP_DENY_DATA     8'h00
`define CFP_ALL_ONES      8'hFF
`endif

// *** include/cfp_pkg.sv ***
// Types for the configuration fuse and protection block.
// Assumes cfp_params.svh is on the include path.
`include "cfp_params.svh"
package cfp_pkg;
	typedef enum logic [1:0] {
		CFP_REGION_BOOT,
		CFP_REGION_BLOCK,
		CFP_REGION_OTHER
	} cfp_region_type;
endpackage

// *** core/cfp_region_decode.sv ***
// Address to region decoder for program memory protection.
// Assumes addresses are program memory byte addresses.
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_region_decode (
	input  wire logic [`CFP_ADDR_W-1:0] addr_in,
	output cfp_pkg::cfp_region_type     region_out,
	output logic      [1:0]             block_out
);
	always_comb begin
		block_out = addr_in[`CFP_BLK_SHIFT+1:`CFP_BLK_SHIFT];
		if (addr_in <= `CFP_BOOT_END) begin
			region_out = cfp_pkg::CFP_REGION_BOOT;
		end else if (addr_in <= `CFP_BLK_TOP) begin
			region_out = cfp_pkg::CFP_REGION_BLOCK;
		end else begin
			region_out = cfp_pkg::CFP_REGION_OTHER;
		end
	end
endmodule

// *** core/cfp_fuse_core.sv ***
// Configuration fuse bank, protection checks and identification bytes.
// Assumes table accesses arrive as one-cycle strobes synchronous to clk_in.
`timescale 1ns/1ps
`include "cfp_params.svh"
// Contract
// - debug fuse 0 dedicates pins to debug
// - low volt programming enabled when fuse 1
// - stack fault resets only when fuse 1
// - unimplemented config bits read zero
// - code protect fuse 0 protects block
// - code protect fuses only clear
// - eeprom code protect fuse 0 protects
// - boot code protect fuse 0 protects boot
// - write protect fuse 0 blocks writes
// - eeprom write protect fuse 0 blocks writes
// - boot write protect fuse 0 blocks writes
// - config write protect blocks config writes in user mode
// - config write protect changes only externally
// - table read protect denies foreign reads
// - boot table read protect denies foreign reads
// - ident byte one: code low, revision
// - ident bytes form eleven bit part code
// - fuse reads 0 programmed, 1 unprogrammed
module cfp_fuse_core #(
	parameter logic [2:0] PART_CODE_LOW  = 3'h5,
	parameter logic [7:0] PART_CODE_HIGH = 8'h5A,
	parameter logic [4:0] REVISION       = 5'h03
) (
	input  wire logic                   clk_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   ext_prog_mode_in,
	input  wire logic                   tbl_rd_in,
	input  wire logic                   tbl_wr_in,
	input  wire logic [`CFP_ADDR_W-1:0] tbl_addr_in,
	input  wire logic [7:0]             tbl_wdata_in,
	input  wire logic [`CFP_ADDR_W-1:0] exec_addr_in,
	input  wire logic                   stack_fault_in,
	input  wire logic                   debug_pin_a_in,
	input  wire logic                   debug_pin_b_in,
	output logic [7:0]                  tbl_rdata_out,
	output logic                        tbl_rd_denied_out,
	output logic                        mem_wr_allow_out,
	output logic                        cfg_wr_done_out,
	output logic                        ee_wr_allow_out,
	output logic                        ee_read_protect_out,
	output logic                        debug_enable_out,
	output logic                        debug_pin_a_out,
	output logic                        debug_pin_a_oe_out,
	output logic                        debug_pin_b_out,
	output logic                        debug_pin_b_oe_out,
	output logic                        debug_pins_gpio_out,
	output logic                        low_volt_prog_enable_out,
	output logic                        stack_reset_out,
	output logic [10:0]                 part_id_out
);
	// Fuse cells; their erased state is ones in every implemented bit and zero elsewhere.
	logic [7:0] debug_program_stack_cfg_ff = `CFP_MASK_DBG;
	logic [7:0] block_code_protect_cfg_ff = `CFP_MASK_BLK;
	logic [7:0] boot_eeprom_code_protect_cfg_ff = `CFP_MASK_CPH;
	logic [7:0] block_write_protect_cfg_ff = `CFP_MASK_BLK;
	logic [7:0] boot_eeprom_cfg_write_protect_ff = `CFP_MASK_WPH;
	logic [7:0] block_table_read_protect_cfg_ff = `CFP_MASK_BLK;
	logic [7:0] boot_table_read_protect_cfg_ff = `CFP_MASK_TRH;
	logic [7:0] nxt_rdata;
	logic       nxt_denied;
	logic [7:0] tbl_rdata_ff;
	logic       tbl_rd_denied_ff;
	logic       stack_reset_ff;
	logic       cfg_wr_done_ff;
	logic       cfg_wr_ok;
	logic       mem_wr_ok;
	logic       rd_ok;
	logic       in_cfg;
	cfp_pkg::cfp_region_type tgt_region;
	cfp_pkg::cfp_region_type src_region;
	logic [1:0] tgt_block;
	logic [1:0] src_block;
	logic       code_protect_block0;
	logic       code_protect_block1;
	logic       code_protect_block2;
	logic       code_protect_block3;
	logic       eeprom_code_protect;
	logic       boot_code_protect;
	logic       eeprom_write_protect;
	logic       boot_write_protect;
	logic       config_write_protect;
	logic       boot_table_read_protect;
	logic       code_prot_hit;
	logic       debug_pin_b_ff;

	cfp_region_decode u_tgt (
		.addr_in    (tbl_addr_in),
		.region_out (tgt_region),
		.block_out  (tgt_block)
	);
	cfp_region_decode u_src (
		.addr_in    (exec_addr_in),
		.region_out (src_region),
		.block_out  (src_block)
	);

	assign code_protect_block0 = block_code_protect_cfg_ff[0];
	assign code_protect_block1 = block_code_protect_cfg_ff[1];
	assign code_protect_block2 = block_code_protect_cfg_ff[2];
	assign code_protect_block3 = block_code_protect_cfg_ff[3];
	assign eeprom_code_protect =
		boot_eeprom_code_protect_cfg_ff[`CFP_BIT_EE];
	assign boot_code_protect =
		boot_eeprom_code_protect_cfg_ff[`CFP_BIT_BOOT];
	assign eeprom_write_protect =
		boot_eeprom_cfg_write_protect_ff[`CFP_BIT_EE];
	assign boot_write_protect =
		boot_eeprom_cfg_write_protect_ff[`CFP_BIT_BOOT];
	assign config_write_protect =
		boot_eeprom_cfg_write_protect_ff[`CFP_BIT_CFGWP];
	assign boot_table_read_protect =
		boot_table_read_protect_cfg_ff[`CFP_BIT_BOOT];

	// Config space writes need the config write protect fuse erased or external programming mode.
	assign in_cfg = (tbl_addr_in >= `CFP_CFG_LO) &&
		(tbl_addr_in <= `CFP_CFG_HI);
	assign cfg_wr_ok = tbl_wr_in && in_cfg &&
		(config_write_protect || ext_prog_mode_in);

	// Program memory write permission toward the flash engine.
	always_comb begin
		mem_wr_ok = 1'b1;
		unique case (tgt_region)
			cfp_pkg::CFP_REGION_BOOT:
				mem_wr_ok = boot_write_protect;
			cfp_pkg::CFP_REGION_BLOCK:
				mem_wr_ok = block_write_protect_cfg_ff[tgt_block];
			cfp_pkg::CFP_REGION_OTHER:
				mem_wr_ok = 1'b1;
		endcase
	end
	assign mem_wr_allow_out = mem_wr_ok;

	// Table reads of a protected block from foreign code are denied.
	always_comb begin
		rd_ok = 1'b1;
		unique case (tgt_region)
			cfp_pkg::CFP_REGION_BOOT:
				rd_ok = boot_table_read_protect ||
					(src_region == cfp_pkg::CFP_REGION_BOOT);
			cfp_pkg::CFP_REGION_BLOCK:
				rd_ok = block_table_read_protect_cfg_ff[tgt_block] ||
					((src_region == cfp_pkg::CFP_REGION_BLOCK) &&
					(src_block == tgt_block));
			cfp_pkg::CFP_REGION_OTHER:
				rd_ok = 1'b1;
		endcase
	end

	// Read mux; unimplemented bits read zero because fuse writes store them masked.
	always_comb begin
		nxt_rdata = `CFP_DENY_DATA;
		nxt_denied = 1'b0;
		unique case (tbl_addr_in)
			`CFP_OFS_DBG: nxt_rdata = debug_program_stack_cfg_ff;
			`CFP_OFS_CP:  nxt_rdata = block_code_protect_cfg_ff;
			`CFP_OFS_CPH: nxt_rdata = boot_eeprom_code_protect_cfg_ff;
			`CFP_OFS_WP:  nxt_rdata = block_write_protect_cfg_ff;
			`CFP_OFS_WPH: nxt_rdata = boot_eeprom_cfg_write_protect_ff;
			`CFP_OFS_TR:  nxt_rdata = block_table_read_protect_cfg_ff;
			`CFP_OFS_TRH: nxt_rdata = boot_table_read_protect_cfg_ff;
			`CFP_OFS_ID1: nxt_rdata = {PART_CODE_LOW, REVISION};
			`CFP_OFS_ID2: nxt_rdata = PART_CODE_HIGH;
			default:      nxt_denied = !rd_ok ||
				(ext_prog_mode_in && code_prot_hit);
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tbl_rdata_ff <= `CFP_DENY_DATA;
			tbl_rd_denied_ff <= 1'b0;
		end else if (tbl_rd_in) begin
			tbl_rdata_ff <= nxt_rdata;
			tbl_rd_denied_ff <= nxt_denied;
		end
	end
	assign tbl_rdata_out = tbl_rdata_ff;
	assign tbl_rd_denied_out = tbl_rd_denied_ff;

	// Fuse bank: kept across device reset, erased state is ones in every implemented bit.
	always_ff @(posedge clk_in) begin
		if (cfg_wr_ok) begin
			unique case (tbl_addr_in)
				`CFP_OFS_DBG: debug_program_stack_cfg_ff <=
					tbl_wdata_in & `CFP_MASK_DBG;
				`CFP_OFS_CP: block_code_protect_cfg_ff <=
					block_code_protect_cfg_ff & tbl_wdata_in &
					`CFP_MASK_BLK;
				`CFP_OFS_CPH: boot_eeprom_code_protect_cfg_ff <=
					boot_eeprom_code_protect_cfg_ff & tbl_wdata_in &
					`CFP_MASK_CPH;
				`CFP_OFS_WP: block_write_protect_cfg_ff <=
					tbl_wdata_in & `CFP_MASK_BLK;
				`CFP_OFS_WPH: begin
					boot_eeprom_cfg_write_protect_ff <=
						tbl_wdata_in & `CFP_MASK_WPH;
					if (!ext_prog_mode_in) begin
						boot_eeprom_cfg_write_protect_ff[`CFP_BIT_CFGWP]
							<= config_write_protect;
					end
				end
				`CFP_OFS_TR: block_table_read_protect_cfg_ff <=
					tbl_wdata_in & `CFP_MASK_BLK;
				`CFP_OFS_TRH: boot_table_read_protect_cfg_ff <=
					tbl_wdata_in & `CFP_MASK_TRH;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cfg_wr_done_ff <= 1'b0;
		end else begin
			cfg_wr_done_ff <= cfg_wr_ok;
		end
	end
	assign cfg_wr_done_out = cfg_wr_done_ff;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			stack_reset_ff <= 1'b0;
		end else begin
			stack_reset_ff <= stack_fault_in &&
				debug_program_stack_cfg_ff[`CFP_BIT_STACK];
		end
	end
	assign stack_reset_out = stack_reset_ff;

	assign debug_enable_out =
		!debug_program_stack_cfg_ff[`CFP_BIT_DEBUG];
	assign debug_pins_gpio_out = !debug_enable_out;
	// Debug link forms pin b data but holds its output enable low; pin a stays a clock input.
	assign debug_pin_a_out = 1'b0;
	assign debug_pin_a_oe_out = 1'b0;
	// The data pin level is registered so the pad never sees a glitch.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			debug_pin_b_ff <= 1'b0;
		end else begin
			debug_pin_b_ff <= debug_enable_out && debug_pin_a_in &&
				!debug_pin_b_in;
		end
	end
	assign debug_pin_b_out = debug_pin_b_ff;
	assign debug_pin_b_oe_out = 1'b0;
	assign low_volt_prog_enable_out =
		debug_program_stack_cfg_ff[`CFP_BIT_LVP];
	assign ee_wr_allow_out = eeprom_write_protect;
	assign ee_read_protect_out = !eeprom_code_protect;
	assign part_id_out = {PART_CODE_HIGH, PART_CODE_LOW};

	// Code protection toward the external programmer read path.
	always_comb begin
		code_prot_hit = 1'b0;
		unique case (tgt_region)
			cfp_pkg::CFP_REGION_BOOT:
				code_prot_hit = !boot_code_protect;
			cfp_pkg::CFP_REGION_BLOCK:
				code_prot_hit = !block_code_protect_cfg_ff[tgt_block];
			cfp_pkg::CFP_REGION_OTHER:
				code_prot_hit = 1'b0;
		endcase
	end

	stack_reset_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (stack_fault_in &&
		debug_program_stack_cfg_ff[`CFP_BIT_STACK]) |=> stack_reset_out)
		else $error("stack fault did not reset");
	stack_quiet_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) !debug_program_stack_cfg_ff[`CFP_BIT_STACK]
		|=> !stack_reset_out)
		else $error("stack reset while disabled");
	cfgwp_hold_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) !ext_prog_mode_in |=> $stable(config_write_protect))
		else $error("config protect changed in user mode");
	cp_clear_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (block_code_protect_cfg_ff & ~$past(
		block_code_protect_cfg_ff)) == 8'h00)
		else $error("code protect bit was set");
	unimpl_zero_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (debug_program_stack_cfg_ff & ~`CFP_MASK_DBG) ==
		8'h00 && (boot_table_read_protect_cfg_ff & ~`CFP_MASK_TRH) == 8'h00)
		else $error("unimplemented bit set");
	cfg_wr_blk_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_wr_in && !config_write_protect &&
		!ext_prog_mode_in) |=> !cfg_wr_done_out)
		else $error("protected config write went through");
	wr_done_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_wr_in && in_cfg && config_write_protect)
		|=> cfg_wr_done_out)
		else $error("open config write not accepted");
	boot_wr_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tgt_region == cfp_pkg::CFP_REGION_BOOT &&
		!boot_write_protect) |-> !mem_wr_allow_out)
		else $error("boot write allowed");
	blk_wr_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tgt_region == cfp_pkg::CFP_REGION_BLOCK &&
		!block_write_protect_cfg_ff[tgt_block]) |-> !mem_wr_allow_out)
		else $error("block write allowed");
	ee_wr_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) !eeprom_write_protect |-> !ee_wr_allow_out)
		else $error("eeprom write allowed");
	ee_cp_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) ee_read_protect_out == !eeprom_code_protect)
		else $error("eeprom protect level wrong");
	rd_deny_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_rd_in && nxt_denied) |=>
		(tbl_rd_denied_out && tbl_rdata_out == `CFP_DENY_DATA))
		else $error("denied read leaked data");
	tr_deny_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_rd_in &&
		tgt_region == cfp_pkg::CFP_REGION_BLOCK &&
		!block_table_read_protect_cfg_ff[tgt_block] &&
		!(src_region == cfp_pkg::CFP_REGION_BLOCK &&
		src_block == tgt_block)) |=> tbl_rd_denied_out)
		else $error("foreign block read allowed");
	boot_rd_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_rd_in &&
		tgt_region == cfp_pkg::CFP_REGION_BOOT &&
		!boot_table_read_protect &&
		src_region != cfp_pkg::CFP_REGION_BOOT) |=> tbl_rd_denied_out)
		else $error("foreign boot read allowed");
	ident_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_rd_in && tbl_addr_in == `CFP_OFS_ID1) |=>
		tbl_rdata_out[7:5] == part_id_out[2:0])
		else $error("ident byte mismatch");
	cp_hit_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_rd_in && ext_prog_mode_in &&
		tgt_region == cfp_pkg::CFP_REGION_BLOCK &&
		!block_code_protect_cfg_ff[tgt_block]) |=> tbl_rd_denied_out)
		else $error("code protect missed");
	boot_cp_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) (tbl_rd_in && ext_prog_mode_in &&
		tgt_region == cfp_pkg::CFP_REGION_BOOT &&
		!boot_code_protect) |=> tbl_rd_denied_out)
		else $error("boot code protect missed");
	dbg_en_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) debug_enable_out ==
		!debug_program_stack_cfg_ff[`CFP_BIT_DEBUG])
		else $error("debug enable level wrong");
	lvp_a: assert property (@(posedge clk_in) disable iff
		(sys_rst_in) low_volt_prog_enable_out ==
		debug_program_stack_cfg_ff[`CFP_BIT_LVP])
		else $error("low volt programming level wrong");
endmodule

// *** bench/cfp_fuse_core_test.sv ***
// Self-checking bench for the configuration fuse and protection core.
// Assumes the design files and cfp_params.svh are compiled beforehand.
`timescale 1ns/1ps
module cfp_fuse_core_test;
	logic        clk_in           = 1'b0;
	logic        sys_rst_in       = 1'b1;
	logic        ext_prog_mode_in = 1'b0;
	logic        tbl_rd_in        = 1'b0;
	logic        tbl_wr_in        = 1'b0;
	logic [21:0] tbl_addr_in      = 22'h000000;
	logic [7:0]  tbl_wdata_in     = 8'h00;
	logic [21:0] exec_addr_in     = 22'h002000;
	logic        stack_fault_in   = 1'b0;
	logic        pin_a            = 1'b0;
	logic        pin_b            = 1'b1;
	logic [7:0]  tbl_rdata_out;
	logic        tbl_rd_denied_out;
	logic        mem_wr_allow_out;
	logic        cfg_wr_done_out;
	logic        ee_wr_allow_out;
	logic        ee_read_protect_out;
	logic        debug_enable_out;
	logic        debug_pins_gpio_out;
	logic        low_volt_prog_enable_out;
	logic        stack_reset_out;
	logic [10:0] part_id_out;
	logic        dbg_a;
	logic        dbg_a_oe;
	logic        dbg_b;
	logic        dbg_b_oe;
	int          fails        = 0;
	int          total_checks = 0;
	logic [21:0] ofs [7] = '{22'h300006, 22'h300008, 22'h300009, 22'h30000A,
		22'h30000B, 22'h30000C, 22'h30000D};
	logic [7:0]  rv [7] = '{8'h85, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};

	cfp_fuse_core u_dut (
		.clk_in                   (clk_in),
		.sys_rst_in               (sys_rst_in),
		.ext_prog_mode_in         (ext_prog_mode_in),
		.tbl_rd_in                (tbl_rd_in),
		.tbl_wr_in                (tbl_wr_in),
		.tbl_addr_in              (tbl_addr_in),
		.tbl_wdata_in             (tbl_wdata_in),
		.exec_addr_in             (exec_addr_in),
		.stack_fault_in           (stack_fault_in),
		.debug_pin_a_in           (pin_a),
		.debug_pin_b_in           (pin_b),
		.tbl_rdata_out            (tbl_rdata_out),
		.tbl_rd_denied_out        (tbl_rd_denied_out),
		.mem_wr_allow_out         (mem_wr_allow_out),
		.cfg_wr_done_out          (cfg_wr_done_out),
		.ee_wr_allow_out          (ee_wr_allow_out),
		.ee_read_protect_out      (ee_read_protect_out),
		.debug_enable_out         (debug_enable_out),
		.debug_pin_a_out          (dbg_a),
		.debug_pin_a_oe_out       (dbg_a_oe),
		.debug_pin_b_out          (dbg_b),
		.debug_pin_b_oe_out       (dbg_b_oe),
		.debug_pins_gpio_out      (debug_pins_gpio_out),
		.low_volt_prog_enable_out (low_volt_prog_enable_out),
		.stack_reset_out          (stack_reset_out),
		.part_id_out              (part_id_out)
	);

	always #2 clk_in = ~clk_in;

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Read strobe for one cycle; data is valid one cycle after the strobe.
	task automatic rd(input logic [21:0] a, input logic [7:0] e);
		@(negedge clk_in);
		tbl_addr_in = a;
		tbl_rd_in = 1'b1;
		@(negedge clk_in);
		tbl_rd_in = 1'b0;
		chk({3'h0, tbl_rdata_out}, {3'h0, e});
	endtask

	task automatic wr(input logic [21:0] a, input logic [7:0] d,
		input logic e);
		@(negedge clk_in);
		tbl_addr_in = a;
		tbl_wdata_in = d;
		tbl_wr_in = 1'b1;
		@(negedge clk_in);
		tbl_wr_in = 1'b0;
		chk({10'h0, cfg_wr_done_out}, {10'h0, e});
	endtask

	task automatic wa(input logic [21:0] a, input logic e);
		@(negedge clk_in);
		tbl_addr_in = a;
		#1;
		chk({10'h0, mem_wr_allow_out}, {10'h0, e});
	endtask

	task automatic stk(input logic e);
		@(negedge clk_in);
		stack_fault_in = 1'b1;
		@(negedge clk_in);
		chk({10'h0, stack_reset_out}, {10'h0, e});
		stack_fault_in = 1'b0;
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		finish_test();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		sys_rst_in = 1'b0;
		foreach (ofs[i]) rd(ofs[i], rv[i]);
		rd(22'h300000, 8'h00);
		chk({10'h0, debug_enable_out}, 11'h000);
		chk({10'h0, debug_pins_gpio_out}, 11'h001);
		chk({10'h0, low_volt_prog_enable_out}, 11'h001);
		$display("test reset_values done");
		rd(22'h3FFFFE, 8'hA3);
		rd(22'h3FFFFF, 8'h5A);
		chk(part_id_out, 11'h2D5);
		$display("test ident done");
		stk(1'b1);
		wr(22'h300006, 8'h7A, 1'b1);
		rd(22'h300006, 8'h00);
		chk({10'h0, debug_enable_out}, 11'h001);
		chk({10'h0, debug_pins_gpio_out}, 11'h000);
		chk({10'h0, low_volt_prog_enable_out}, 11'h000);
		chk({7'h0, dbg_a, dbg_a_oe, dbg_b, dbg_b_oe}, 11'h000);
		stk(1'b0);
		wr(22'h300006, 8'hFF, 1'b1);
		rd(22'h300006, 8'h85);
		$display("test debug_options done");
		wr(22'h300008, 8'h0E, 1'b1);
		wr(22'h300008, 8'h0F, 1'b1);
		rd(22'h300008, 8'h0E);
		wr(22'h300009, 8'h40, 1'b1);
		chk({10'h0, ee_read_protect_out}, 11'h001);
		rd(22'h300009, 8'h40);
		$display("test code_protect done");
		wa(22'h002000, 1'b1);
		wr(22'h30000A, 8'h0D, 1'b1);
		wa(22'h002000, 1'b0);
		wa(22'h004000, 1'b1);
		wa(22'h000100, 1'b1);
		wr(22'h30000B, 8'hA0, 1'b1);
		wa(22'h000100, 1'b0);
		chk({10'h0, ee_wr_allow_out}, 11'h001);
		wr(22'h30000B, 8'h40, 1'b1);
		chk({10'h0, ee_wr_allow_out}, 11'h000);
		rd(22'h30000B, 8'h60);
		$display("test write_protect done");
		rd(22'h000300, 8'h00);
		chk({10'h0, tbl_rd_denied_out}, 11'h000);
		wr(22'h30000C, 8'h0E, 1'b1);
		rd(22'h000300, 8'h00);
		chk({10'h0, tbl_rd_denied_out}, 11'h001);
		exec_addr_in = 22'h000400;
		rd(22'h000300, 8'h00);
		chk({10'h0, tbl_rd_denied_out}, 11'h000);
		exec_addr_in = 22'h002000;
		wr(22'h30000D, 8'h00, 1'b1);
		rd(22'h000010, 8'h00);
		chk({10'h0, tbl_rd_denied_out}, 11'h001);
		rd(22'h30000D, 8'h00);
		rd(22'h30000C, 8'h0E);
		rd(22'h3000FF, 8'h00);
		$display("test table_read_protect done");
		wr(22'h300100, 8'h00, 1'b0);
		ext_prog_mode_in = 1'b1;
		exec_addr_in = 22'h000400;
		rd(22'h000300, 8'h00);
		chk({10'h0, tbl_rd_denied_out}, 11'h001);
		rd(22'h002000, 8'h00);
		chk({10'h0, tbl_rd_denied_out}, 11'h000);
		wr(22'h30000B, 8'hC0, 1'b1);
		ext_prog_mode_in = 1'b0;
		rd(22'h30000B, 8'hC0);
		wr(22'h30000A, 8'h0F, 1'b0);
		rd(22'h30000A, 8'h0D);
		$display("test config_protect done");
		finish_test();
	end
endmodule
